// ==== hw/supply_sel_regs.svh ====
/*
 Timing constants and channel count for the prioritized supply selector.
 Assumes inclusion by the validator and selector files; needs no package.
*/
`ifndef SUPPLY_SEL_REGS_SVH
`define SUPPLY_SEL_REGS_SVH
`define CLK_MHZ          250
`define VALID_TIME_MS    256
`define FAULT_TIME_US    8
`define SOFT_TIME_MS     32
`define VALID_CYCLES     (`VALID_TIME_MS * 1000 * `CLK_MHZ)
`define FAULT_CYCLES     (`FAULT_TIME_US * `CLK_MHZ)
`define SOFT_CYCLES      (`SOFT_TIME_MS * 1000 * `CLK_MHZ)
`define NUM_CH           3
`endif

// ==== hw/supply_sel_pkg.sv ====
/*
 Types shared by the supply selector.
 Assumes nothing of its surroundings.
*/
package supply_sel_pkg;
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_RELEASE = 4'h2,
      ST_WAITREV = 4'h4,
      ST_ON      = 4'h8
   } sel_state_t;
endpackage

// ==== hw/chan_validator.sv ====
/*
 One channel's window validation: synchronizer, fault filter and timer.
 Assumes comparator flags are asynchronous and active high.
*/
`timescale 1ns/1ps
`include "supply_sel_regs.svh"
module chan_validator #(
   parameter int VALID_CNT = `VALID_CYCLES,
   parameter int FAULT_CNT = `FAULT_CYCLES
)(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Comparator flags, asynchronous
   input  wire logic over_limit,
   input  wire logic under_limit,
   // Monitoring allowed
   input  wire logic monitor_en,
   // Results
   output logic      valid,
   output logic      fault_filtered
);
   logic [1:0] s_over;
   logic [1:0] s_under;
   logic [31:0] vcnt;
   logic [31:0] next_vcnt;
   logic [31:0] fcnt;
   logic [31:0] next_fcnt;
   logic        next_valid;
   logic        next_fault;
   logic        outside;

   // Two-stage synchronizers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_over  <= 2'h0;
         s_under <= 2'h3;
      end
      else
      begin
         s_over  <= {s_over[0], over_limit};
         s_under <= {s_under[0], under_limit};
      end
   end

   assign outside = s_over[1] | s_under[1];

   // Timer and filter next state
   always_comb
   begin
      next_vcnt  = vcnt;
      next_valid = valid;
      next_fcnt  = fcnt;
      next_fault = fault_filtered;
      if (!monitor_en)
      begin
         next_vcnt  = 32'h0;
         next_valid = 1'b0;
         next_fcnt  = 32'h0;
         next_fault = 1'b0;
      end
      else if (outside)
      begin
         next_vcnt  = 32'h0;
         next_valid = 1'b0;
         if (fcnt >= 32'(FAULT_CNT - 1))
            next_fault = 1'b1;
         else
            next_fcnt = fcnt + 32'h1;
      end
      else
      begin
         next_fcnt  = 32'h0;
         next_fault = 1'b0;
         if (vcnt >= 32'(VALID_CNT - 1))
            next_valid = 1'b1;
         else
            next_vcnt = vcnt + 32'h1;
      end
   end

   // Register timers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         vcnt           <= 32'h0;
         valid          <= 1'b0;
         fcnt           <= 32'h0;
         fault_filtered <= 1'b0;
      end
      else
      begin
         vcnt           <= next_vcnt;
         valid          <= next_valid;
         fcnt           <= next_fcnt;
         fault_filtered <= next_fault;
      end
   end
endmodule

// ==== hw/supply_selector.sv ====
/*
 Prioritized three-input supply selector control logic.
 Assumes comparators and gate drivers outside; all their flags are asynchronous.
*/
`timescale 1ns/1ps
`include "supply_sel_regs.svh"
// Operation
// - Input one has top priority, input three lowest, fixed by position.
// - Input valid after 256 ms continuously in window; connect best valid.
// - Each active-low valid indicator goes low while its input is valid.
// - Connected input out of window 8 us is dropped, next valid connects.
// - Higher input becoming valid replaces a connected lower one.
// - Next channel connects only after releasing gate is latched off.
// - Connection waits for latched reverse-block indication, cleared at turn-off.
// - First connection soft-starts; ends at any disconnect or after 32 ms.
// - After soft-start gates switch fast without ramping.
// - Shutdown release or output below 0.7 V re-arms soft-start.
// - Enable low disconnects all channels; monitoring and indicators continue.
// - Cascade high when all invalid, gates off, enabled; low when any valid.
// - Shutdown disconnects all, disables monitoring and resets validation timers.
module supply_selector #(
   parameter int VALID_CNT = `VALID_CYCLES,
   parameter int FAULT_CNT = `FAULT_CYCLES,
   parameter int SOFT_CNT  = `SOFT_CYCLES
)(
   // Clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   // Window comparator flags, one bit per channel, bit 0 = first
   input  wire logic [2:0] OVER_LIMIT,
   input  wire logic [2:0] UNDER_LIMIT,
   // Control inputs
   input  wire logic       ENABLE,
   input  wire logic       POWER_DOWN_N,
   // Gate and rail sense
   input  wire logic [2:0] GATE_OFF_DETECT,
   input  wire logic [2:0] REVERSE_BLOCK_DETECT,
   input  wire logic       OUTPUT_RAIL_LOW,
   // Gate drive, high = channel on
   output logic [2:0]      GATE_DRIVE,
   output logic            SLEW_LIMIT,
   // Indicators
   output logic [2:0]      INPUT_OK_N,
   output logic            CASCADE_OUT
);
   logic [1:0] s_en;
   logic [1:0] s_pd;
   logic [1:0] s_low;
   logic [2:0] s_goff0;
   logic [2:0] s_goff;
   logic [2:0] s_rev0;
   logic [2:0] s_rev;
   logic       pd_prev;
   logic [2:0] valid;
   logic [2:0] fault;
   logic       monitor_en;
   logic [2:0] best;
   logic [2:0] usable;
   supply_sel_pkg::sel_state_t state;
   supply_sel_pkg::sel_state_t next_state;
   logic [2:0] target;
   logic [2:0] next_target;
   logic [2:0] next_gate;
   logic [2:0] off_latch;
   logic [2:0] next_off_latch;
   logic [2:0] rev_latch;
   logic [2:0] next_rev_latch;
   logic       soft_armed;
   logic       next_soft_armed;
   logic       next_slew;
   logic [31:0] scnt;
   logic [31:0] next_scnt;
   logic [2:0] next_ok_n;
   logic       next_cas;
   logic       run;

   // Control synchronizers
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         s_en    <= 2'h0;
         s_pd    <= 2'h0;
         s_low   <= 2'h3;
         s_goff0 <= 3'h7;
         s_goff  <= 3'h7;
         s_rev0  <= 3'h0;
         s_rev   <= 3'h0;
         pd_prev <= 1'b0;
      end
      else
      begin
         s_en    <= {s_en[0], ENABLE};
         s_pd    <= {s_pd[0], POWER_DOWN_N};
         s_low   <= {s_low[0], OUTPUT_RAIL_LOW};
         s_goff0 <= GATE_OFF_DETECT;
         s_goff  <= s_goff0;
         s_rev0  <= REVERSE_BLOCK_DETECT;
         s_rev   <= s_rev0;
         pd_prev <= s_pd[1];
      end
   end

   assign monitor_en = s_pd[1];
   assign run        = s_pd[1] & s_en[1];

   // Per-channel validation
   genvar g;
   generate
      for (g = 0; g < `NUM_CH; g++)
      begin : g_ch
         chan_validator #(
            .VALID_CNT (VALID_CNT),
            .FAULT_CNT (FAULT_CNT)
         ) u_val (
            .clk            (CLK_SYS),
            .rst            (RST),
            .over_limit     (OVER_LIMIT[g]),
            .under_limit    (UNDER_LIMIT[g]),
            .monitor_en     (monitor_en),
            .valid          (valid[g]),
            .fault_filtered (fault[g])
         );
      end
   endgenerate

   // Connected channel rides out an excursion until its fault filter trips
   assign usable = (valid | GATE_DRIVE) & ~fault;

   // Highest-priority usable channel, bit 0 wins
   always_comb
   begin
      best = 3'h0;
      if (usable[0])
         best = 3'h1;
      else if (usable[1])
         best = 3'h2;
      else if (usable[2])
         best = 3'h4;
   end

   // Selection sequencer next state
   always_comb
   begin
      next_state     = state;
      next_target    = target;
      next_gate      = GATE_DRIVE;
      next_off_latch = off_latch | s_goff;
      next_rev_latch = rev_latch | (s_rev & target);
      unique case (state)
         supply_sel_pkg::ST_IDLE:
         begin
            if (run && best != 3'h0)
            begin
               next_target = best;
               next_state  = supply_sel_pkg::ST_WAITREV;
            end
         end
         supply_sel_pkg::ST_RELEASE:
         begin
            // Break before make: wait for all gates latched off
            if ((off_latch & s_goff) == 3'h7)
               next_state = supply_sel_pkg::ST_IDLE;
         end
         supply_sel_pkg::ST_WAITREV:
         begin
            if (!run || best != target)
               next_state = supply_sel_pkg::ST_IDLE;
            else if ((rev_latch & target) != 3'h0)
            begin
               next_gate      = target;
               next_off_latch = off_latch & ~target;
               next_state     = supply_sel_pkg::ST_ON;
            end
         end
         supply_sel_pkg::ST_ON:
         begin
            // Drop on fault, better input, or disable
            if (!run || best != target)
            begin
               next_gate      = 3'h0;
               next_rev_latch = 3'h0;
               next_state     = supply_sel_pkg::ST_RELEASE;
            end
            else
               next_off_latch = off_latch & ~target;
         end
      endcase
   end

   // Soft-start control next state
   always_comb
   begin
      next_soft_armed = soft_armed;
      next_slew       = SLEW_LIMIT;
      next_scnt       = scnt;
      if (state == supply_sel_pkg::ST_WAITREV && next_state == supply_sel_pkg::ST_ON
          && soft_armed)
      begin
         next_slew       = 1'b1;
         next_soft_armed = 1'b0;
         next_scnt       = 32'h0;
      end
      else if (SLEW_LIMIT)
      begin
         if (next_state == supply_sel_pkg::ST_RELEASE || scnt >= 32'(SOFT_CNT - 1))
            next_slew = 1'b0;
         else
            next_scnt = scnt + 32'h1;
      end
      // Re-arm wins over use in the same cycle
      if ((s_pd[1] && !pd_prev) || s_low[1])
         next_soft_armed = 1'b1;
   end

   // Indicators next state
   always_comb
   begin
      next_ok_n = ~valid;
      next_cas  = CASCADE_OUT;
      if (!s_pd[1])
         next_cas = 1'b1;
      else if (!s_en[1] || valid != 3'h0)
         next_cas = 1'b0;
      else if (s_goff == 3'h7)
         next_cas = 1'b1;
   end

   // Register all state
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         state       <= supply_sel_pkg::ST_IDLE;
         target      <= 3'h0;
         GATE_DRIVE  <= 3'h0;
         off_latch   <= 3'h0;
         rev_latch   <= 3'h0;
         soft_armed  <= 1'b1;
         SLEW_LIMIT  <= 1'b0;
         scnt        <= 32'h0;
         INPUT_OK_N  <= 3'h7;
         CASCADE_OUT <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         target      <= next_target;
         GATE_DRIVE  <= next_gate;
         off_latch   <= next_off_latch;
         rev_latch   <= next_rev_latch;
         soft_armed  <= next_soft_armed;
         SLEW_LIMIT  <= next_slew;
         scnt        <= next_scnt;
         INPUT_OK_N  <= next_ok_n;
         CASCADE_OUT <= next_cas;
      end
   end

   // Checks
   sequence seq_drop;
      state == supply_sel_pkg::ST_ON && !run;
   endsequence

   AST_ONE_HOT_GATE: assert property (@(posedge CLK_SYS) disable iff (RST)
      $countones(GATE_DRIVE) <= 1)
      else $error("more than one gate on");
   AST_DISABLE_OFF: assert property (@(posedge CLK_SYS) disable iff (RST)
      seq_drop |=> GATE_DRIVE == 3'h0)
      else $error("gate not dropped on disable");
   AST_ON_NEEDS_REV: assert property (@(posedge CLK_SYS) disable iff (RST)
      $rose(GATE_DRIVE != 3'h0) |-> $past(rev_latch & target) != 3'h0)
      else $error("gate on without reverse block");
   AST_ON_NEEDS_OFF: assert property (@(posedge CLK_SYS) disable iff (RST)
      $rose(GATE_DRIVE != 3'h0) |-> $past(state) == supply_sel_pkg::ST_WAITREV)
      else $error("gate on without release sequence");
   AST_OK_TRACKS: assert property (@(posedge CLK_SYS) disable iff (RST)
      ##1 INPUT_OK_N == ~$past(valid))
      else $error("valid indicator mismatch");
   AST_PRIORITY: assert property (@(posedge CLK_SYS) disable iff (RST)
      GATE_DRIVE != 3'h0 && valid[0] && !fault[0] |-> ##[0:2] GATE_DRIVE != 3'h2
      && GATE_DRIVE != 3'h4 || GATE_DRIVE == 3'h0)
      else $error("lower channel kept over first");
   AST_POWER_DOWN_N_CAS: assert property (@(posedge CLK_SYS) disable iff (RST)
      !s_pd[1] |=> CASCADE_OUT && valid == 3'h0)
      else $error("shutdown cascade or timers wrong");
   AST_SLEW_ENDS: assert property (@(posedge CLK_SYS) disable iff (RST)
      $fell(GATE_DRIVE != 3'h0) |-> !SLEW_LIMIT)
      else $error("slew kept through disconnect");
   AST_SOFT_ON_CONNECT: assert property (@(posedge CLK_SYS) disable iff (RST)
      $rose(SLEW_LIMIT) |-> $rose(GATE_DRIVE != 3'h0))
      else $error("slew started without a connection");
   AST_FAULT_DROP: assert property (@(posedge CLK_SYS) disable iff (RST)
      (GATE_DRIVE & fault) != 3'h0 |=> GATE_DRIVE == 3'h0)
      else $error("faulted channel kept connected");
   AST_POWER_DOWN_N_OFF: assert property (@(posedge CLK_SYS) disable iff (RST)
      !s_pd[1] |=> GATE_DRIVE == 3'h0)
      else $error("gate on during shutdown");
   AST_CAS_LOW_EN: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_pd[1] && !s_en[1] |=> !CASCADE_OUT)
      else $error("cascade high while disabled");
endmodule

// ==== test/gate_driver_model.sv ====
/*
 Behavioural model of the external gate drivers and the reverse-block sense.
 Assumes one gate drive bit per channel, high = channel on; slow stretches settle time.
*/
`timescale 1ns/1ps
module gate_driver_model (
   // Clock and speed select
   input  wire logic       clk,
   input  wire logic       slow,
   // Gate commands from the selector
   input  wire logic [2:0] gate_drive,
   // Sense flags back to the selector
   output logic [2:0]      gate_off_detect,
   output logic [2:0]      reverse_block_detect
);
   logic [3:0] off_cnt [3] = '{4'hF, 4'hF, 4'hF};
   logic [3:0] droop_cnt   = 4'hF;
   logic [3:0] lim;

   // Settle time of a gate or of the output droop
   assign lim = slow ? 4'h9 : 4'h1;

   // Gate discharge and output droop counters
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (gate_drive[i])
            off_cnt[i] <= 4'h0;
         else if (off_cnt[i] != 4'hF)
            off_cnt[i] <= off_cnt[i] + 4'h1;
      end
      if (|gate_drive)
         droop_cnt <= 4'h0;
      else if (droop_cnt != 4'hF)
         droop_cnt <= droop_cnt + 4'h1;
   end

   // Gate reads off only after it has discharged
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         gate_off_detect[i] = off_cnt[i] >= lim;
   end

   // Output sits below every input only once all gates are off and it has drooped
   assign reverse_block_detect = {3{droop_cnt >= lim}};
endmodule

// ==== test/supply_selector_tb.sv ====
/*
 Self-checking bench for the supply selector, with directed and random stimulus.
 Assumes the gate driver model in its own file and shortened timing counts.
*/
`timescale 1ns/1ps
module supply_selector_tb;
   localparam int VALID_CNT = 200;
   localparam int FAULT_CNT = 8;
   localparam int SOFT_CNT  = 100;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [2:0] over_lim = 3'h0;
   logic [2:0] under_lim = 3'h0;
   logic       enable = 1'b1;
   logic       pwr_dn_n = 1'b1;
   logic       rail_low = 1'b0;
   logic       slow = 1'b0;
   logic [2:0] gate_off;
   logic [2:0] rev_blk;
   logic [2:0] gate;
   logic       slew;
   logic [2:0] ok_n;
   logic       cascade;
   logic [2:0] prev_gate = 3'h0;
   logic [2:0] rev_seen = 3'h0;
   logic [7:0] seed = 8'h55;
   int         err_count = 0;
   int         n_compared = 0;

   // 250 MHz clock
   always #2 clk = ~clk;

   supply_selector #(.VALID_CNT(VALID_CNT), .FAULT_CNT(FAULT_CNT), .SOFT_CNT(SOFT_CNT)) DUT (
      .CLK_SYS(clk), .RST(rst), .OVER_LIMIT(over_lim), .UNDER_LIMIT(under_lim),
      .ENABLE(enable), .POWER_DOWN_N(pwr_dn_n), .GATE_OFF_DETECT(gate_off),
      .REVERSE_BLOCK_DETECT(rev_blk), .OUTPUT_RAIL_LOW(rail_low), .GATE_DRIVE(gate),
      .SLEW_LIMIT(slew), .INPUT_OK_N(ok_n), .CASCADE_OUT(cascade));

   gate_driver_model partner (
      .clk(clk), .slow(slow), .gate_drive(gate),
      .gate_off_detect(gate_off), .reverse_block_detect(rev_blk));

   // Pseudo-random source
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic complete_run;
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Advance n cycles and settle past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Bounded wait for a gate pattern
   task automatic wait_gate(input logic [2:0] exp, input int bound);
      int k;
      for (k = 0; k < bound && gate !== exp; k++)
         tick(1);
      if (gate !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t gate %h exp %h", $time, gate, exp);
         complete_run();
      end
   endtask

   // Enable dropped and restored, with an optional output rail collapse
   task automatic bounce(input logic collapse);
      @(posedge clk) enable <= 1'b0;
      tick(5);
      chk3(gate, 3'h0);
      chk3(ok_n, 3'h0);
      chk1(cascade, 1'b0);
      @(posedge clk) rail_low <= collapse;
      tick(4);
      @(posedge clk) rail_low <= 1'b0;
      enable <= 1'b1;
      wait_gate(3'h1, 20);
      chk1(slew, collapse);
   endtask

   // Continuous break-before-make and reverse-block watch
   always @(negedge clk)
   begin
      if (rst === 1'b0)
      begin
         chk1($onehot0(gate), 1'b1);
         chk3(gate & ~prev_gate & ~rev_seen, 3'h0);
      end
      // Reverse-block seen since the channel last turned off
      rev_seen = (rev_seen | rev_blk) & ~(prev_gate & ~gate);
      prev_gate = gate;
   end

   initial
   begin
      tick(5);
      @(posedge clk) rst <= 1'b0;
      tick(1);
      chk3(gate, 3'h0);
      chk3(ok_n, 3'h7);
      // All inputs good: first channel soft-starts, then slew ends
      wait_gate(3'h1, VALID_CNT + 20);
      chk3(ok_n, 3'h0);
      chk1(slew, 1'b1);
      tick(SOFT_CNT + 5);
      chk1(slew, 1'b0);
      // Fault on the connected channel: filtered, then next channel
      @(posedge clk) under_lim <= 3'h1;
      tick(5);
      chk3(gate, 3'h1);
      wait_gate(3'h2, FAULT_CNT + 20);
      chk3(ok_n, 3'h1);
      chk1(slew, 1'b0);
      @(posedge clk) under_lim <= 3'h0;
      @(posedge clk) slow <= 1'b1;
      wait_gate(3'h1, VALID_CNT + 40);
      bounce(1'b0);
      bounce(1'b1);
      // Shutdown clears validity; release re-arms soft-start
      @(posedge clk) pwr_dn_n <= 1'b0;
      tick(6);
      chk3(gate, 3'h0);
      chk3(ok_n, 3'h7);
      chk1(cascade, 1'b1);
      @(posedge clk) pwr_dn_n <= 1'b1;
      tick(30);
      chk1(cascade, 1'b1);
      wait_gate(3'h1, VALID_CNT + 20);
      chk1(slew, 1'b1);
      @(posedge clk) over_lim <= 3'h1;
      wait_gate(3'h2, FAULT_CNT + 40);
      chk1(slew, 1'b0);
      chk1(cascade, 1'b0);
      // Random flag activity under the watchers
      for (int c = 0; c < 3000; c++)
      begin
         @(posedge clk);
         seed = lfsr_next(seed);
         if (seed[3:0] == 4'h0)
         begin
            over_lim <= seed[6:4] & {2'h0, seed[7]};
            under_lim <= seed[6:4];
            slow <= seed[7];
         end
      end
      @(posedge clk) over_lim <= 3'h0;
      under_lim <= 3'h0;
      wait_gate(3'h1, VALID_CNT + 60);
      complete_run();
   end
endmodule
